// *** rtl/can_tx_err.sv ***
`include "can_defines.svh"

// Notes on behaviour
// - Receive warning when receive count reaches 96
// - Receive count above 127 gives receive passive
// - Any receive error marks invalid message
// - Overrun event sets that buffer's overrun flag
// - Three fourteen-byte transmit buffers
// - Two-bit priority, 11 highest, 00 lowest
// - Request bit enqueues; priority read at start
// - Setting request clears abort flag; clears lost, error flags unless that buffer fails in the same cycle
// - Idle bus starts highest priority pending buffer
// - Success clears request, flags enabled interrupt
// - Failure keeps request; error sets error flag
// - Lost arbitration flagged, never interrupts
// - Abort when unstarted or failed; no interrupt
// - Ack, form, bit errors each count one
// - Transmit count above 96 sets summary and warning
// - Empty buffer flags drive transmit interrupt
// - Transmit count above 127 gives transmit passive
// - Transmit count above 255 gives bus off
// - Receive errors raise summary error flag
// - Bit time split into whole-quantum segments
// - Bit time 8 to 25 quanta, at least 1 us
module can_tx_err import can_pkg::*; #(
  parameter int NRX   = 2,
  parameter int DEPTH = 8
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire buf_write_t  BUF_WR,
  input  wire logic [5:0]  TX_PRIO,
  input  wire logic [2:0]  REQ_SET,
  input  wire logic [2:0]  REQ_CLR,
  input  wire logic        ABORT_ALL,
  input  wire logic        TX_IRQ_EN,
  input  wire logic [2:0]  BUF_IRQ_CLR,
  input  wire logic [15:0] FLAG_CLR,
  input  wire logic        BUS_IDLE,
  input  wire tx_result_t  TX_RESULT,
  input  wire logic        RX_OK,
  input  wire logic        RX_ERR,
  input  wire logic [NRX-1:0] RX_OVR,
  input  wire logic        RECOVER,
  input  wire bit_timing_t TIMING,
  output logic             TX_VALID,
  input  wire logic        TX_READY,
  output logic [7:0]       TX_BYTE,
  output logic [1:0]       TX_BUF,
  output logic [23:0]      BUF_CON,
  output logic [15:0]      INTF,
  output logic [7:0]       TEC,
  output logic [7:0]       REC,
  output logic             TX_IRQ,
  output logic             ERR_IRQ,
  output logic             TIMING_OK
);
  initial begin
    if (NRX < 1 || NRX > 4) $error("NRX must be 1 to 4");
  end

  function automatic logic [1:0] pick(input logic [2:0] pend, input logic [5:0] pri);
    logic [1:0] best;
    logic [2:0] bp;
    best = 2'h0;
    bp   = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (pend[i] && {1'b1, pri[2*i +: 2]} >= bp) begin
        best = 2'(i);
        bp   = {1'b1, pri[2*i +: 2]};
      end
    end
    return best;
  endfunction

  function automatic logic [8:0] sat_add(input logic [8:0] v, input logic [1:0] n);
    logic [9:0] s;
    s = {1'b0, v} + {8'h00, n};
    return s[9] ? 9'h1FF : s[8:0];
  endfunction

  logic [7:0] mem_ff [3][`CAN_BUF_BYTES];

  always_ff @(posedge CLK) begin
    if (BUF_WR.wr && BUF_WR.sel != 2'h3 && BUF_WR.addr < 4'(`CAN_BUF_BYTES)) begin
      mem_ff[BUF_WR.sel][BUF_WR.addr] <= BUF_WR.data;
    end
  end

  logic idle_m_ff, idle_s_ff;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      idle_m_ff <= 1'b0;
      idle_s_ff <= 1'b0;
    end else begin
      idle_m_ff <= BUS_IDLE;
      idle_s_ff <= idle_m_ff;
    end
  end

  tx_state_t  st_ff, nxt_st;
  logic [1:0] cur_ff, nxt_cur;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [2:0] req_ff, abt_ff, larb_ff, terr_ff, irq_ff;
  logic [2:0] nxt_req, nxt_abt, nxt_larb, nxt_terr, nxt_irq;
  logic [8:0] tec_ff, nxt_tec, rec_ff, nxt_rec;
  logic       ivr_ff, nxt_ivr, sum_ff, nxt_sum, boff_ff, nxt_boff;
  logic [NRX-1:0] ovr_ff, nxt_ovr;
  logic       f_valid, f_ready, push;
  logic [1:0] nerr;
  logic       fail;
  logic       f_pop;
  logic [9:0] f_data;

  always_comb begin
    nxt_st   = st_ff;
    nxt_cur  = cur_ff;
    nxt_cnt  = cnt_ff;
    nxt_req  = req_ff & ~REQ_CLR;
    nxt_abt  = abt_ff | (req_ff & REQ_CLR);
    nxt_larb = larb_ff;
    nxt_terr = terr_ff;
    nxt_irq  = irq_ff & ~BUF_IRQ_CLR;
    nxt_tec  = tec_ff;
    nxt_rec  = rec_ff;
    nxt_boff = boff_ff;
    push     = 1'b0;
    nerr     = 2'(TX_RESULT.ack_err) + 2'(TX_RESULT.form_err) + 2'(TX_RESULT.bit_err);
    fail     = TX_RESULT.arb_lost | (nerr != 2'h0);
    if (ABORT_ALL) begin
      nxt_req = 3'h0;
      nxt_abt = abt_ff | req_ff;
    end
    if (st_ff != S_IDLE) begin
      nxt_req[cur_ff] = req_ff[cur_ff] & ~REQ_CLR[cur_ff] & ~ABORT_ALL;
      nxt_abt[cur_ff] = abt_ff[cur_ff];
    end
    case (st_ff)
      S_IDLE: begin
        if (idle_s_ff && !boff_ff && |nxt_req) begin
          nxt_cur = pick(nxt_req, TX_PRIO);
          nxt_cnt = 4'h0;
          nxt_st  = S_LOAD;
        end
      end
      S_LOAD: begin
        push = 1'b1;
        if (f_ready) begin
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == 4'(`CAN_BUF_BYTES - 1)) begin
            nxt_st = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        if (TX_RESULT.ok) begin
          nxt_req[cur_ff] = 1'b0;
          nxt_irq[cur_ff] = nxt_irq[cur_ff] | TX_IRQ_EN;
          if (tec_ff != 9'h000 && !boff_ff) begin
            nxt_tec = tec_ff - 9'h001;
          end
          nxt_st = S_IDLE;
        end else if (fail) begin
          if (TX_RESULT.arb_lost) begin
            nxt_larb[cur_ff] = 1'b1;
          end
          if (nerr != 2'h0) begin
            nxt_terr[cur_ff] = 1'b1;
            nxt_tec          = sat_add(tec_ff, nerr);
          end
          if (!nxt_req[cur_ff]) begin
            nxt_abt[cur_ff] = 1'b1;
          end
          nxt_st = S_IDLE;
        end
      end
      default: nxt_st = S_IDLE;
    endcase
    for (int i = 0; i < 3; i++) begin
      if (REQ_SET[i]) begin
        nxt_req[i] = 1'b1;
        nxt_abt[i] = 1'b0;
        if (!(st_ff == S_WAIT && fail && cur_ff == 2'(i))) begin
          nxt_larb[i] = 1'b0;
          nxt_terr[i] = 1'b0;
        end
      end
    end
    if (RX_ERR) begin
      nxt_rec = sat_add(rec_ff, 2'h1);
    end else if (RX_OK && rec_ff != 9'h000) begin
      nxt_rec = rec_ff - 9'h001;
    end
    if (nxt_tec > `CAN_BUSOFF_LIMIT) begin
      nxt_boff = 1'b1;
    end
    if (RECOVER && boff_ff) begin
      nxt_boff = 1'b0;
      nxt_tec  = 9'h000;
      nxt_rec  = 9'h000;
    end
  end

  logic transmit_warning_flag, transmit_passive_flag, receive_warning_flag, receive_passive_flag, nxt_transmit_warning_flag_q;
  logic transmit_warning_flag_ff, transmit_passive_flag_ff, receive_passive_flag_ff;
  always_comb begin
    transmit_warning_flag = nxt_tec > `CAN_WARN_LIMIT;
    transmit_passive_flag  = nxt_tec > `CAN_PASSIVE_LIMIT;
    receive_warning_flag = nxt_rec >= `CAN_WARN_LIMIT;
    receive_passive_flag  = nxt_rec > `CAN_PASSIVE_LIMIT;
    nxt_transmit_warning_flag_q = transmit_warning_flag;
    nxt_ivr = (ivr_ff & ~FLAG_CLR[`INTF_IVR_BIT]) | RX_ERR;
    nxt_ovr = (ovr_ff & ~FLAG_CLR[`INTF_OVR_LSB +: NRX]) | RX_OVR;
    nxt_sum = (sum_ff & ~FLAG_CLR[`INTF_ERR_BIT])
            | RX_ERR | (|RX_OVR) | (receive_passive_flag & ~receive_passive_flag_ff)
            | (transmit_warning_flag & ~transmit_warning_flag_ff)
            | (transmit_passive_flag & ~transmit_passive_flag_ff) | (nxt_boff & ~boff_ff)
            | (st_ff == S_WAIT && nerr != 2'h0);
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_ff    <= S_IDLE;
      cur_ff   <= 2'h0;
      cnt_ff   <= 4'h0;
      req_ff   <= 3'h0;
      abt_ff   <= 3'h0;
      larb_ff  <= 3'h0;
      terr_ff  <= 3'h0;
      irq_ff   <= 3'h0;
      tec_ff   <= 9'h000;
      rec_ff   <= 9'h000;
      boff_ff  <= 1'b0;
      ivr_ff   <= 1'b0;
      ovr_ff   <= '0;
      sum_ff   <= 1'b0;
      transmit_warning_flag_ff <= 1'b0;
      transmit_passive_flag_ff  <= 1'b0;
      receive_passive_flag_ff  <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cur_ff   <= nxt_cur;
      cnt_ff   <= nxt_cnt;
      req_ff   <= nxt_req;
      abt_ff   <= nxt_abt;
      larb_ff  <= nxt_larb;
      terr_ff  <= nxt_terr;
      irq_ff   <= nxt_irq;
      tec_ff   <= nxt_tec;
      rec_ff   <= nxt_rec;
      boff_ff  <= nxt_boff;
      ivr_ff   <= nxt_ivr;
      ovr_ff   <= nxt_ovr;
      sum_ff   <= nxt_sum;
      transmit_warning_flag_ff <= nxt_transmit_warning_flag_q;
      transmit_passive_flag_ff  <= transmit_passive_flag;
      receive_passive_flag_ff  <= receive_passive_flag;
    end
  end

  tx_fifo #(
    .WIDTH (10),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .resetn    (RESETN),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   ({cur_ff, mem_ff[cur_ff][cnt_ff]}),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  logic       ov_ff, nxt_ov;
  logic [9:0] od_ff, nxt_od;
  always_comb begin
    f_pop  = !ov_ff || TX_READY;
    nxt_ov = f_pop ? f_valid : ov_ff;
    nxt_od = (f_pop && f_valid) ? f_data : od_ff;
  end

  logic [5:0]  ntq;
  logic [7:0]  tq_clk;
  logic [11:0] bit_clk;
  logic        nxt_tok, tok_ff;
  always_comb begin
    ntq     = 6'h1 + 6'(TIMING.prop) + 6'(TIMING.phase1) + 6'(TIMING.phase2) + 6'h3;
    tq_clk  = {1'b0, TIMING.brp, 1'b0} + 8'h02;
    bit_clk = 12'(tq_clk) * 12'(ntq);
    nxt_tok = ntq >= `CAN_TQ_MIN && ntq <= `CAN_TQ_MAX
            && bit_clk >= 12'(`CAN_MIN_BIT_CLK);
  end

  logic [23:0] nxt_con;
  logic [15:0] nxt_intf;
  always_comb begin
    nxt_con  = '0;
    nxt_intf = '0;
    for (int i = 0; i < 3; i++) begin
      nxt_con[8*i + `CON_PRI_LSB +: 2] = TX_PRIO[2*i +: 2];
      nxt_con[8*i + `CON_REQ_BIT]      = nxt_req[i];
      nxt_con[8*i + `CON_ERR_BIT]      = nxt_terr[i];
      nxt_con[8*i + `CON_LARB_BIT]     = nxt_larb[i];
      nxt_con[8*i + `CON_ABT_BIT]      = nxt_abt[i];
      nxt_con[8*i + `CON_IRQ_BIT]      = nxt_irq[i];
    end
    nxt_intf[`INTF_IVR_BIT]          = nxt_ivr;
    nxt_intf[`INTF_OVR_LSB +: NRX]   = nxt_ovr;
    nxt_intf[`INTF_ERR_BIT]          = nxt_sum;
    nxt_intf[`INTF_RECEIVE_WARNING_FLAG_BIT]        = receive_warning_flag;
    nxt_intf[`INTF_RECEIVE_PASSIVE_FLAG_BIT]         = receive_passive_flag;
    nxt_intf[`INTF_TRANSMIT_WARNING_FLAG_BIT]        = transmit_warning_flag;
    nxt_intf[`INTF_TRANSMIT_PASSIVE_FLAG_BIT]         = transmit_passive_flag;
    nxt_intf[`INTF_BUS_OFF_FLAG_BIT]         = nxt_boff;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ov_ff     <= 1'b0;
      od_ff     <= '0;
      tok_ff    <= 1'b0;
      BUF_CON   <= '0;
      INTF      <= '0;
      TEC       <= 8'h00;
      REC       <= 8'h00;
      TX_IRQ    <= 1'b0;
      ERR_IRQ   <= 1'b0;
    end else begin
      ov_ff     <= nxt_ov;
      od_ff     <= nxt_od;
      tok_ff    <= nxt_tok;
      BUF_CON   <= nxt_con;
      INTF      <= nxt_intf;
      TEC       <= nxt_tec[8] ? 8'hFF : nxt_tec[7:0];
      REC       <= nxt_rec[8] ? 8'hFF : nxt_rec[7:0];
      TX_IRQ    <= |nxt_irq;
      ERR_IRQ   <= nxt_sum;
    end
  end

  always_comb begin
    TX_VALID  = ov_ff;
    TX_BYTE   = od_ff[7:0];
    TX_BUF    = od_ff[9:8];
    TIMING_OK = tok_ff;
  end
endmodule

// *** rtl/can_defines.svh ***
`ifndef CAN_DEFINES_SVH
`define CAN_DEFINES_SVH
`define CAN_WARN_LIMIT    9'h060
`define CAN_PASSIVE_LIMIT 9'h07F
`define CAN_BUSOFF_LIMIT  9'h0FF
`define CAN_BUF_BYTES     14
`define CAN_TQ_MIN        6'h08
`define CAN_TQ_MAX        6'h19
`define CAN_CLK_NS        20
`define CAN_MIN_BIT_NS    1000
`define CAN_MIN_BIT_CLK   ((`CAN_MIN_BIT_NS + `CAN_CLK_NS - 1) / `CAN_CLK_NS)
`define CON_PRI_LSB       0
`define CON_REQ_BIT       3
`define CON_ERR_BIT       4
`define CON_LARB_BIT      5
`define CON_ABT_BIT       6
`define CON_IRQ_BIT       7
`define INTF_IVR_BIT      0
`define INTF_OVR_LSB      1
`define INTF_ERR_BIT      5
`define INTF_RECEIVE_WARNING_FLAG_BIT    8
`define INTF_RECEIVE_PASSIVE_FLAG_BIT     9
`define INTF_TRANSMIT_WARNING_FLAG_BIT    10
`define INTF_TRANSMIT_PASSIVE_FLAG_BIT     12
`define INTF_BUS_OFF_FLAG_BIT     13
`endif

// *** rtl/can_pkg.sv ***
package can_pkg;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_LOAD = 2'b01,
    S_WAIT = 2'b10
  } tx_state_t;

  typedef struct packed {
    logic ok;
    logic arb_lost;
    logic ack_err;
    logic form_err;
    logic bit_err;
  } tx_result_t;

  typedef struct packed {
    logic       wr;
    logic [1:0] sel;
    logic [3:0] addr;
    logic [7:0] data;
  } buf_write_t;

  typedef struct packed {
    logic [3:0] phase2;
    logic [3:0] phase1;
    logic [3:0] prop;
    logic [5:0] brp;
  } bit_timing_t;
endpackage

// *** rtl/tx_fifo.sv ***
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wptr_ff, rptr_ff, nxt_wptr, nxt_rptr;
  logic             push, pop;

  always_comb begin
    in_ready  = (wptr_ff - rptr_ff) != (AW+1)'(DEPTH);
    out_valid = wptr_ff != rptr_ff;
    out_data  = mem_ff[rptr_ff[AW-1:0]];
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    nxt_wptr  = wptr_ff + (AW+1)'(push);
    nxt_rptr  = rptr_ff + (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wptr_ff[AW-1:0]] <= in_data;
    end
  end
endmodule

// *** verification/can_tx_err_asserts.sv ***
module can_tx_err_asserts import can_pkg::*; (
  input wire logic        CLK,
  input wire logic        RESETN,
  input wire logic [2:0]  REQ_SET,
  input wire tx_result_t  TX_RESULT,
  input wire bit_timing_t TIMING,
  input wire logic        TX_VALID,
  input wire logic        TX_READY,
  input wire logic [7:0]  TX_BYTE,
  input wire logic [23:0] BUF_CON,
  input wire logic [15:0] INTF,
  input wire logic [7:0]  TEC,
  input wire logic [7:0]  REC,
  input wire logic        TIMING_OK
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  int   ntq;
  logic t_ok;
  assign ntq = 4 + TIMING.prop + TIMING.phase1 + TIMING.phase2;
  assign t_ok = ntq >= 8 && ntq <= 25 && 2 * (TIMING.brp + 1) * ntq >= 50;
  sequence s_req; REQ_SET[0] && TX_RESULT == '0; endsequence
  sequence s_stall; TX_VALID && !TX_READY; endsequence
  property p_receive_warning_flag; $stable(REC) |-> INTF[8] == (REC >= 8'h60); endproperty
  property p_receive_passive_flag; $stable(REC) |-> INTF[9] == (REC > 8'h7F); endproperty
  property p_transmit_passive_flag; $stable(TEC) |-> INTF[12] == (TEC > 8'h7F); endproperty
  property p_bo; INTF[13] |-> TEC == 8'hFF; endproperty
  property p_req; s_req |=> BUF_CON[3] && BUF_CON[6:4] == 3'h0; endproperty
  property p_arb; $rose(BUF_CON[13]) |-> !$rose(BUF_CON[15]); endproperty
  property p_abt; $rose(BUF_CON[6]) |-> !$rose(BUF_CON[7]) && !BUF_CON[3]; endproperty
  property p_hold; s_stall |=> TX_VALID && $stable(TX_BYTE); endproperty
  property p_tok; $past(RESETN) |-> TIMING_OK == $past(t_ok); endproperty
  a_receive_warning_flag: assert property (p_receive_warning_flag) else $error("rx warning flag");
  a_receive_passive_flag: assert property (p_receive_passive_flag) else $error("rx passive flag");
  a_transmit_passive_flag: assert property (p_transmit_passive_flag) else $error("tx passive flag");
  a_bo: assert property (p_bo) else $error("bus off count");
  a_req: assert property (p_req) else $error("request set");
  a_arb: assert property (p_arb) else $error("lost with irq");
  a_abt: assert property (p_abt) else $error("abort with irq");
  a_hold: assert property (p_hold) else $error("byte not held");
  a_tok: assert property (p_tok) else $error("timing check");
endmodule
bind can_tx_err can_tx_err_asserts chk_u (.CLK(CLK), .RESETN(RESETN), .REQ_SET(REQ_SET),
  .TX_RESULT(TX_RESULT), .TIMING(TIMING), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
  .TX_BYTE(TX_BYTE), .BUF_CON(BUF_CON), .INTF(INTF), .TEC(TEC), .REC(REC),
  .TIMING_OK(TIMING_OK));

// *** verification/can_engine_model.sv ***
module can_engine_model import can_pkg::*; (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       tx_valid,
  input  wire logic [1:0] kind,
  output logic            tx_ready,
  output tx_result_t      result
);
  timeunit 1ns;
  timeprecision 1ns;
  int n;
  // Random stalls; after 14 bytes reports the commanded outcome
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      n <= 0;
      tx_ready <= 1'h0;
      result <= '0;
    end else begin
      result <= '0;
      tx_ready <= 1'($urandom_range(1));
      if (tx_valid && tx_ready)
        n <= n + 1;
      if (n == 14) begin
        n <= 0;
        result <= kind == 2'h0 ? 5'h10 : kind == 2'h1 ? 5'h08 : kind == 2'h2 ? 5'h04 : 5'h03;
      end
    end
  end
endmodule

// *** verification/can_tx_err_tb.sv ***
module can_tx_err_tb;
  import can_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLK = '0, RESETN = '0, ABORT_ALL = '0, TX_IRQ_EN = 1'h1, BUS_IDLE = '0;
  logic        RX_OK = '0, RX_ERR = '0, RECOVER = '0, TX_VALID, TX_READY, TX_IRQ, ERR_IRQ;
  logic        TIMING_OK, inv = '0, sum = '0;
  logic [2:0]  REQ_SET = '0, REQ_CLR = '0, BUF_IRQ_CLR = '0;
  logic [2:0]  req = '0, irq = '0, abt = '0, lst = '0, err = '0;
  logic [1:0]  RX_OVR = '0, TX_BUF, kind = '0, ovr = '0, lb;
  logic [5:0]  TX_PRIO = '0;
  logic [15:0] FLAG_CLR = '0, INTF;
  logic [7:0]  TX_BYTE, TEC, REC, mem[3][14], q[$];
  logic [23:0] BUF_CON;
  buf_write_t  BUF_WR = '0;
  bit_timing_t TIMING = '0;
  tx_result_t  TX_RESULT;
  int          n_fail = 0, tests_run = 0, cyc = 0, tec = 0, rec = 0;

  can_tx_err dut_u (.CLK(CLK), .RESETN(RESETN), .BUF_WR(BUF_WR), .TX_PRIO(TX_PRIO),
    .REQ_SET(REQ_SET), .REQ_CLR(REQ_CLR), .ABORT_ALL(ABORT_ALL), .TX_IRQ_EN(TX_IRQ_EN),
    .BUF_IRQ_CLR(BUF_IRQ_CLR), .FLAG_CLR(FLAG_CLR), .BUS_IDLE(BUS_IDLE),
    .TX_RESULT(TX_RESULT), .RX_OK(RX_OK), .RX_ERR(RX_ERR), .RX_OVR(RX_OVR),
    .RECOVER(RECOVER), .TIMING(TIMING), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .TX_BYTE(TX_BYTE), .TX_BUF(TX_BUF), .BUF_CON(BUF_CON), .INTF(INTF), .TEC(TEC),
    .REC(REC), .TX_IRQ(TX_IRQ), .ERR_IRQ(ERR_IRQ), .TIMING_OK(TIMING_OK));
  can_engine_model eng_u (.clk(CLK), .resetn(RESETN), .tx_valid(TX_VALID), .kind(kind),
    .tx_ready(TX_READY), .result(TX_RESULT));

  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    if (TX_VALID && TX_READY) begin
      q.push_back(TX_BYTE);
      lb = TX_BUF;
    end
    if (++cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(logic [23:0] seen, logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] xcon();
    logic [23:0] c = '0;
    for (int i = 0; i < 3; i++)
      c[8*i +: 8] = {irq[i], abt[i], lst[i], err[i], req[i], 1'h0, TX_PRIO[2*i +: 2]};
    return c;
  endfunction
  function automatic logic [15:0] xintf();
    return {2'h0, tec > 255, tec > 127, 1'h0, tec > 96, rec > 127, rec >= 96, 2'h0, sum,
            2'h0, ovr, inv};
  endfunction
  function automatic logic tok(bit_timing_t t);
    int n = 4 + t.prop + t.phase1 + t.phase2;
    return n >= 8 && n <= 25 && 2 * (t.brp + 1) * n >= 50;
  endfunction
  task automatic settle();
    repeat (2) @(negedge CLK);
    chk(BUF_CON, xcon());
    chk(INTF, xintf());
    chk(TEC, tec > 255 ? 255 : tec);
    chk(REC, rec);
    chk({TX_IRQ, ERR_IRQ}, {|irq, sum});
  endtask
  task automatic ctl(logic [2:0] s, c, i, logic a, logic [15:0] f);
    @(posedge CLK);
    {REQ_SET, REQ_CLR, BUF_IRQ_CLR, ABORT_ALL, FLAG_CLR} <= {s, c, i, a, f};
    @(posedge CLK);
    {REQ_SET, REQ_CLR, BUF_IRQ_CLR, ABORT_ALL, FLAG_CLR} <= '0;
    abt = (abt | req & (c | {3{a}})) & ~s;
    req = req & ~c & ~{3{a}} | s;
    {lst, err, irq} = {lst & ~s, err & ~s, irq & ~i};
    {sum, ovr, inv} = {sum, ovr, inv} & ~{f[5], f[2:1], f[0]};
    settle();
  endtask
  task automatic rx(logic o, e, logic [1:0] v, int n);
    @(posedge CLK);
    {RX_OK, RX_ERR, RX_OVR} <= {o, e, v};
    repeat (n) @(posedge CLK);
    {RX_OK, RX_ERR, RX_OVR} <= '0;
    rec += n * (int'(e) - int'(o));
    {inv, ovr, sum} = {inv | e, ovr | v, sum | e | (|v)};
    settle();
  endtask
  task automatic frame(logic [1:0] k, int b);
    int t = 0;
    @(posedge CLK);
    kind <= k;
    q = {};
    do @(negedge CLK); while (TX_RESULT === '0 && ++t < 900);
    chk(24'(t < 900), 24'h1);
    chk(lb, b);
    chk(q.size(), 14);
    foreach (mem[b][i]) chk(q[i], mem[b][i]);
    req[b] = k != 0;
    irq[b] = irq[b] | k == 0 & TX_IRQ_EN;
    lst[b] = lst[b] | k == 1;
    err[b] = err[b] | k > 1;
    sum = sum | k > 1;
    tec = k == 0 ? tec - (tec > 0) : tec + (k > 1) + (k == 3);
    settle();
  endtask

  initial begin
    void'($urandom(77806));
    foreach (mem[b, i]) mem[b][i] = 8'($urandom);
    repeat (8) @(posedge CLK);
    RESETN <= 1'h1;
    settle();
    foreach (mem[b, i]) begin
      @(posedge CLK);
      BUF_WR <= {1'h1, 2'(b), 4'(i), mem[b][i]};
    end
    @(posedge CLK);
    BUF_WR <= {1'h1, 2'h3, 4'h0, 8'h5A};
    @(posedge CLK);
    BUF_WR <= '0;
    TX_PRIO <= 6'h1B;
    ctl(3'h7, '0, '0, '0, '0);
    @(posedge CLK);
    {TX_PRIO, BUS_IDLE} <= {6'h2D, 1'h1};
    frame(0, 1);
    frame(0, 2);
    frame(0, 0);
    ctl('0, '0, 3'h7, '0, '0);
    ctl(3'h2, '0, '0, '0, '0);
    frame(1, 1);
    frame(2, 1);
    while (tec <= 255) frame(3, 1);
    q = {};
    repeat (40) @(negedge CLK);
    chk(q.size(), 0);
    @(posedge CLK);
    {RECOVER, TX_IRQ_EN} <= 2'h2;
    @(posedge CLK);
    RECOVER <= '0;
    tec = 0;
    frame(0, 1);
    @(posedge CLK);
    BUS_IDLE <= '0;
    repeat (3) @(posedge CLK);
    ctl(3'h5, '0, '0, '0, '0);
    ctl('0, 3'h1, '0, '0, '0);
    ctl('0, '0, '0, 1'h1, '0);
    ctl(3'h4, 3'h4, '0, '0, '0);
    ctl('0, '0, '0, '0, 16'hFFFF);
    rx(0, 1, 0, 95);
    rx(0, 1, 0, 1);
    rx(0, 1, 0, 32);
    rx(1, 0, 0, 1);
    rx(0, 0, 2'h2, 1);
    repeat (20) begin
      @(posedge CLK);
      TIMING <= 18'($urandom);
      repeat (2) @(negedge CLK);
      chk(TIMING_OK, tok(TIMING));
    end
    complete_run();
  end
endmodule
